// [shared/ictc_pkg.sv]
// Package: register map, field positions and timing for the counter/timer control block
package ictc_pkg;
  localparam int ICTC_AW = 10;
  localparam logic [9:0] ICTC_OFF_IRQ_FLAGS = 10'h207;
  localparam logic [9:0] ICTC_OFF_CORE_DATA0 = 10'h208;
  localparam logic [9:0] ICTC_OFF_CORE_DATA1 = 10'h209;
  localparam logic [9:0] ICTC_OFF_CORE_CTRL = 10'h20b;
  localparam logic [9:0] ICTC_OFF_GATE_OUT0 = 10'h20c;
  localparam logic [9:0] ICTC_OFF_GATE_OUT1 = 10'h20d;
  localparam logic [9:0] ICTC_OFF_SETTINGS0 = 10'h20e;
  localparam logic [9:0] ICTC_OFF_SETTINGS1 = 10'h20f;
  // Field positions
  localparam int ICTC_BIT_FLAG0 = 2;
  localparam int ICTC_BIT_FLAG1 = 3;
  localparam int ICTC_BIT_SOFT_GATE = 0;
  localparam int ICTC_BIT_OUT_LEVEL = 4;
  localparam int ICTC_BIT_CLK_SEL = 0;
  localparam int ICTC_BIT_GATE_SEL = 1;
  localparam int ICTC_BIT_OUT_ROUTE = 2;
  localparam int ICTC_BIT_IRQ_EN = 3;
  localparam int ICTC_BIT_TB_LOW = 4;
  localparam int ICTC_BIT_TB_HIGH = 5;
  localparam int ICTC_BIT_CASCADE = 6;
  // Reset values
  localparam logic [7:0] ICTC_RST_SETTINGS = 8'h00;
  localparam logic [1:0] ICTC_RST_SOFT_GATE = 2'h0;
  localparam logic [15:0] ICTC_RST_COUNT = 16'hffff;
  localparam logic [15:0] ICTC_MIN_COUNT = 16'h0002;
  // Timing: clock rate and time base rates
  localparam int ICTC_CLK_HZ = 40_000_000;
  localparam int ICTC_TB0_HZ = 100_000;
  localparam int ICTC_TB1_HZ = 10_000;
  localparam int ICTC_TB2_HZ = 1_000;
  localparam int ICTC_TB3_HZ = 100;
  localparam int ICTC_TB0_CYC = ICTC_CLK_HZ / ICTC_TB0_HZ;
  localparam int ICTC_TB1_CYC = ICTC_CLK_HZ / ICTC_TB1_HZ;
  localparam int ICTC_TB2_CYC = ICTC_CLK_HZ / ICTC_TB2_HZ;
  localparam int ICTC_TB3_CYC = ICTC_CLK_HZ / ICTC_TB3_HZ;

  // Per-counter settings fields
  typedef struct packed {
    logic irq_en;
    logic out_route;
    logic gate_sel;
    logic clk_sel;
  } ictc_cfg_t;

  // Register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ictc_req_t;

  typedef enum logic [1:0] {
    ICTC_TB_100K,
    ICTC_TB_10K,
    ICTC_TB_1K,
    ICTC_TB_100
  } ictc_tb_sel_t;
endpackage

// [rtl/ictc_timebase.sv]
// Internal time base: one-cycle tick at the selected rate
`timescale 1ns/100ps
`default_nettype none
module ictc_timebase
  import ictc_pkg::*;
#(
  parameter int DIV0 = ICTC_TB0_CYC,
  parameter int DIV1 = ICTC_TB1_CYC,
  parameter int DIV2 = ICTC_TB2_CYC,
  parameter int DIV3 = ICTC_TB3_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Rate select and tick
  input wire logic [1:0] sel,
  output logic tick
);
  logic [21:0] cnt_q;
  logic [21:0] limit;

  always_comb begin
    case (sel)
      2'h0: limit = 22'(DIV0 - 1);
      2'h1: limit = 22'(DIV1 - 1);
      2'h2: limit = 22'(DIV2 - 1);
      default: limit = 22'(DIV3 - 1);
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || cnt_q >= limit) begin
      cnt_q <= 22'h000000;
    end else begin
      cnt_q <= cnt_q + 22'h000001;
    end
  end

  assign tick = !rst && (cnt_q >= limit);
endmodule // ictc_timebase
`default_nettype wire

// [rtl/ictc_down_counter.sv]
// 16-bit down counter, rate-generator style, with loadable reload value
`timescale 1ns/100ps
`default_nettype none
module ictc_down_counter
  import ictc_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count control
  input wire logic load,
  input wire logic [W-1:0] reload,
  input wire logic step,
  input wire logic gate,
  // State
  output logic [W-1:0] count,
  output logic out
);
  logic [W-1:0] cnt_q;
  logic out_q;

  // Output low for one step at terminal count, reloading on the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '1;
      out_q <= 1'b1;
    end else if (load) begin
      cnt_q <= reload;
      out_q <= 1'b1;
    end else if (step && gate) begin
      if (cnt_q <= W'(2)) begin
        cnt_q <= reload;
        out_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - W'(1);
        out_q <= 1'b1;
      end
    end
  end

  assign count = cnt_q;
  assign out = out_q;
endmodule // ictc_down_counter
`default_nettype wire

// [rtl/ictc_ctrl.sv]
// Isolated counter/timer control: register file, source muxes, flags and cascade
//
// Function
// - Control registers take writes as settings; reads return status.
// - Flag register bit 2 is counter 0 flag, bit 3 counter 1.
// - Flag reads 1 on interrupt; writing 1 clears, 0 does nothing.
// - Bit 0 of each start control register is the software gate.
// - Bit 4 of each start control register reads the counter output level.
// - Bit 0 of each setting register selects the clock source.
// - Counter 0 counts time base when 0, isolated input 1 edges when 1.
// - Counter 1 counts time base when 0, isolated input 3 edges when 1.
// - Bit 1 of each setting register selects the gate source.
// - Gate from soft bit when 0; input 0 or input 2 when 1.
// - Bit 2 of each setting register selects the output destination.
// - Route 1 additionally drives isolated output 2 or 3.
// - Bit 3 enables interrupts; when clear the output sets no flag.
// - Counter 1 setting bits 4 and 5 select the shared time base.
// - Time base 00 100 KHz, 01 10 KHz, 10 1 KHz, 11 100 Hz.
// - Counter 1 setting bit 6 cascades both counters into 32 bits.
// - Each counter is a 16-bit down counter, counts 2 to 65535.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ictc_ctrl
  import ictc_pkg::*;
#(
  parameter int CW = 16,
  parameter int TB_DIV0 = ICTC_TB0_CYC,
  parameter int TB_DIV1 = ICTC_TB1_CYC,
  parameter int TB_DIV2 = ICTC_TB2_CYC,
  parameter int TB_DIV3 = ICTC_TB3_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Isolated field inputs
  input wire logic iso_input_0,
  input wire logic iso_input_1,
  input wire logic iso_input_2,
  input wire logic iso_input_3,
  // Isolated field outputs and their routing enables
  output logic iso_output_2,
  output logic iso_output_2_en,
  output logic iso_output_3,
  output logic iso_output_3_en,
  // Interrupt flags
  output logic first_counter_irq_flag,
  output logic second_counter_irq_flag
);
  ictc_req_t req;
  ictc_cfg_t cfg0_q;
  ictc_cfg_t cfg1_q;
  logic [1:0] tb_sel_q;
  logic cascade_enable_q;
  logic first_counter_soft_gate_q;
  logic second_counter_soft_gate_q;
  logic [1:0] flag_q;
  logic [7:0] rdata_q;
  logic [CW-1:0] reload0_q;
  logic [CW-1:0] reload1_q;
  logic [7:0] core_ctrl_q;
  logic [1:0] lsb_phase_q;
  logic [1:0] load_q;
  logic [1:0] out_prev_q;
  logic [1:0] ext_prev_q;
  logic tb_tick;
  logic [1:0] step;
  logic [1:0] gate;
  logic [1:0] ext_now;
  logic [CW-1:0] count0;
  logic [CW-1:0] count1;
  logic out0;
  logic out1;
  logic [1:0] cnt_out;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Write hit decode, used for every register
  function automatic logic hit_wr(input ictc_req_t r, input logic [9:0] off);
    return r.wr && (r.addr == off);
  endfunction

  // Settings registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg0_q <= ictc_cfg_t'(ICTC_RST_SETTINGS[3:0]);
      cfg1_q <= ictc_cfg_t'(ICTC_RST_SETTINGS[3:0]);
      tb_sel_q <= ICTC_RST_SETTINGS[ICTC_BIT_TB_HIGH:ICTC_BIT_TB_LOW];
      cascade_enable_q <= ICTC_RST_SETTINGS[ICTC_BIT_CASCADE];
    end else begin
      if (hit_wr(req, ICTC_OFF_SETTINGS0)) begin
        cfg0_q.gate_sel <= req.wdata[ICTC_BIT_GATE_SEL];
        cfg0_q.clk_sel <= req.wdata[ICTC_BIT_CLK_SEL];
        cfg0_q.out_route <= req.wdata[ICTC_BIT_OUT_ROUTE];
        cfg0_q.irq_en <= req.wdata[ICTC_BIT_IRQ_EN];
      end
      if (hit_wr(req, ICTC_OFF_SETTINGS1)) begin
        cfg1_q.clk_sel <= req.wdata[ICTC_BIT_CLK_SEL];
        cfg1_q.gate_sel <= req.wdata[ICTC_BIT_GATE_SEL];
        cfg1_q.out_route <= req.wdata[ICTC_BIT_OUT_ROUTE];
        cfg1_q.irq_en <= req.wdata[ICTC_BIT_IRQ_EN];
        tb_sel_q <= req.wdata[ICTC_BIT_TB_HIGH:ICTC_BIT_TB_LOW];
        cascade_enable_q <= req.wdata[ICTC_BIT_CASCADE];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      first_counter_soft_gate_q <= ICTC_RST_SOFT_GATE[0];
      second_counter_soft_gate_q <= ICTC_RST_SOFT_GATE[1];
    end else begin
      if (hit_wr(req, ICTC_OFF_GATE_OUT0)) begin
        first_counter_soft_gate_q <= req.wdata[ICTC_BIT_SOFT_GATE];
      end
      if (hit_wr(req, ICTC_OFF_GATE_OUT1)) begin
        second_counter_soft_gate_q <= req.wdata[ICTC_BIT_SOFT_GATE];
      end
    end
  end

  // core data writes, low byte then high byte, then reload
  always_ff @(posedge clk) begin
    if (rst) begin
      reload0_q <= ICTC_RST_COUNT;
      reload1_q <= ICTC_RST_COUNT;
      core_ctrl_q <= 8'h00;
      lsb_phase_q <= 2'h0;
      load_q <= 2'h0;
    end else begin
      load_q <= 2'h0;
      if (hit_wr(req, ICTC_OFF_CORE_CTRL)) begin
        core_ctrl_q <= req.wdata;
        lsb_phase_q <= 2'h0;
      end
      if (hit_wr(req, ICTC_OFF_CORE_DATA0)) begin
        lsb_phase_q[0] <= ~lsb_phase_q[0];
        if (!lsb_phase_q[0]) begin
          reload0_q[7:0] <= req.wdata;
        end else begin
          reload0_q[15:8] <= req.wdata;
          load_q[0] <= 1'b1;
        end
      end
      if (hit_wr(req, ICTC_OFF_CORE_DATA1)) begin
        lsb_phase_q[1] <= ~lsb_phase_q[1];
        if (!lsb_phase_q[1]) begin
          reload1_q[7:0] <= req.wdata;
        end else begin
          reload1_q[15:8] <= req.wdata;
          load_q[1] <= 1'b1;
        end
      end
    end
  end

  ictc_timebase #(
    .DIV0(TB_DIV0),
    .DIV1(TB_DIV1),
    .DIV2(TB_DIV2),
    .DIV3(TB_DIV3)
  ) u_tb (
    .clk(clk),
    .rst(rst),
    .sel(tb_sel_q),
    .tick(tb_tick)
  );

  // External clock edges on isolated inputs 1 and 3
  assign ext_now = {iso_input_3, iso_input_1};
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev_q <= 2'h0;
    end else begin
      ext_prev_q <= ext_now;
    end
  end

  always_comb begin
    step[0] = cfg0_q.clk_sel ? (ext_now[0] && !ext_prev_q[0]) : tb_tick;
    // counter 1 clock source; cascade clocks from counter 0 output
    if (cascade_enable_q) begin
      step[1] = out_prev_q[0] && !out0;
    end else begin
      step[1] = cfg1_q.clk_sel ? (ext_now[1] && !ext_prev_q[1]) : tb_tick;
    end
    gate[0] = cfg0_q.gate_sel ? iso_input_0 : first_counter_soft_gate_q;
    gate[1] = cfg1_q.gate_sel ? iso_input_2 : second_counter_soft_gate_q;
  end

  ictc_down_counter #(.W(CW)) u_cnt0 (
    .clk(clk),
    .rst(rst),
    .load(load_q[0]),
    .reload(reload0_q),
    .step(step[0]),
    .gate(gate[0]),
    .count(count0),
    .out(out0)
  );

  ictc_down_counter #(.W(CW)) u_cnt1 (
    .clk(clk),
    .rst(rst),
    .load(load_q[1]),
    .reload(reload1_q),
    .step(step[1]),
    .gate(gate[1]),
    .count(count1),
    .out(out1)
  );

  assign cnt_out = {out1, out0};

  always_ff @(posedge clk) begin
    if (rst) begin
      out_prev_q <= 2'h3;
    end else begin
      out_prev_q <= cnt_out;
    end
  end

  // flags set on falling edge of enabled output; set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic ev;
        logic clr;
        ev = out_prev_q[i] && !cnt_out[i] && (i == 0 ? cfg0_q.irq_en : cfg1_q.irq_en);
        clr = hit_wr(req, ICTC_OFF_IRQ_FLAGS) && req.wdata[ICTC_BIT_FLAG0 + i];
        if (ev) begin
          flag_q[i] <= 1'b1;
        end else if (clr) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // route outputs to isolated outputs 2 and 3
  always_ff @(posedge clk) begin
    if (rst) begin
      iso_output_2 <= 1'b0;
      iso_output_3 <= 1'b0;
    end else begin
      iso_output_2 <= cfg0_q.out_route & out0;
      iso_output_3 <= cfg1_q.out_route & out1;
    end
  end
  assign iso_output_2_en = cfg0_q.out_route;
  assign iso_output_3_en = cfg1_q.out_route;

  // reads return status, one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      rdata_q <= 8'h00;
      case (req.addr)
        ICTC_OFF_IRQ_FLAGS: begin
          rdata_q[ICTC_BIT_FLAG0] <= flag_q[0];
          rdata_q[ICTC_BIT_FLAG1] <= flag_q[1];
        end
        ICTC_OFF_CORE_DATA0: rdata_q <= lsb_phase_q[0] ? count0[15:8] : count0[7:0];
        ICTC_OFF_CORE_DATA1: rdata_q <= lsb_phase_q[1] ? count1[15:8] : count1[7:0];
        ICTC_OFF_CORE_CTRL: rdata_q <= core_ctrl_q;
        ICTC_OFF_GATE_OUT0: begin
          rdata_q[ICTC_BIT_OUT_LEVEL] <= out0;
          rdata_q[ICTC_BIT_SOFT_GATE] <= first_counter_soft_gate_q;
        end
        ICTC_OFF_GATE_OUT1: begin
          rdata_q[ICTC_BIT_OUT_LEVEL] <= out1;
          rdata_q[ICTC_BIT_SOFT_GATE] <= second_counter_soft_gate_q;
        end
        ICTC_OFF_SETTINGS0: rdata_q[3:0] <= cfg0_q;
        ICTC_OFF_SETTINGS1: begin
          rdata_q[3:0] <= cfg1_q;
          rdata_q[ICTC_BIT_TB_HIGH:ICTC_BIT_TB_LOW] <= tb_sel_q;
          rdata_q[ICTC_BIT_CASCADE] <= cascade_enable_q;
        end
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_q;
  assign first_counter_irq_flag = flag_q[0];
  assign second_counter_irq_flag = flag_q[1];
endmodule // ictc_ctrl
`default_nettype wire

// [tb/ictc_ctrl_sva.sv]
// Checker: register port, routing and flag relations of the counter/timer control block
`timescale 1ns/100ps
`default_nettype none
module ictc_ctrl_chk
  import ictc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Field side
  input wire logic iso_input_0,
  input wire logic iso_input_1,
  input wire logic iso_input_2,
  input wire logic iso_input_3,
  input wire logic iso_output_2,
  input wire logic iso_output_2_en,
  input wire logic iso_output_3,
  input wire logic iso_output_3_en,
  // Flags
  input wire logic first_counter_irq_flag,
  input wire logic second_counter_irq_flag
);
  logic en0_q;
  // Shadow of the counter 0 interrupt enable
  always_ff @(posedge clk) begin
    if (rst) begin
      en0_q <= 1'b0;
    end else if (wr && addr == ICTC_OFF_SETTINGS0) begin
      en0_q <= wdata[ICTC_BIT_IRQ_EN];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr0; wr && addr == ICTC_OFF_SETTINGS0; endsequence
  sequence s_wr1; wr && addr == ICTC_OFF_SETTINGS1; endsequence
  sequence s_rd1; rd && addr == ICTC_OFF_SETTINGS1; endsequence
  property p_reset_quiet;
    disable iff (1'b0) rst |=> rdata == 8'h00 && !first_counter_irq_flag
      && !second_counter_irq_flag && !iso_output_2_en && !iso_output_3_en;
  endproperty
  property p_route0; s_wr0 |=> iso_output_2_en == $past(wdata[ICTC_BIT_OUT_ROUTE]); endproperty
  property p_route1; s_wr1 |=> iso_output_3_en == $past(wdata[ICTC_BIT_OUT_ROUTE]); endproperty
  property p_unrouted; !iso_output_3_en ##1 !iso_output_3_en |-> !iso_output_3; endproperty
  property p_sticky0;
    first_counter_irq_flag && !(wr && addr == ICTC_OFF_IRQ_FLAGS && wdata[2]) |=>
      first_counter_irq_flag;
  endproperty
  property p_sticky1;
    second_counter_irq_flag && !(wr && addr == ICTC_OFF_IRQ_FLAGS && wdata[3]) |=>
      second_counter_irq_flag;
  endproperty
  property p_irq_off; $rose(first_counter_irq_flag) |-> en0_q || $past(en0_q); endproperty
  property p_rd_flags;
    rd && addr == ICTC_OFF_IRQ_FLAGS |=> rdata[7:4] == 4'h0 && rdata[1:0] == 2'h0;
  endproperty
  property p_rd_hole; rd && addr == 10'h20a |=> rdata == 8'h00; endproperty
  property p_rd_hold; !rd |=> $stable(rdata); endproperty
  property p_set_back; s_wr1 ##2 s_rd1 |=> rdata[6:0] == $past(wdata[6:0], 3); endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet in reset");
  a_route0: assert property (p_route0) else $error("output 2 enable wrong");
  a_route1: assert property (p_route1) else $error("output 3 enable wrong");
  a_unrouted: assert property (p_unrouted) else $error("output 3 driven unrouted");
  a_sticky0: assert property (p_sticky0) else $error("flag 0 dropped");
  a_sticky1: assert property (p_sticky1) else $error("flag 1 dropped");
  a_irq_off: assert property (p_irq_off) else $error("flag 0 set while disabled");
  a_rd_flags: assert property (p_rd_flags) else $error("flag read spare bits");
  a_rd_hole: assert property (p_rd_hole) else $error("hole address read nonzero");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_set_back: assert property (p_set_back) else $error("settings readback wrong");
endmodule // ictc_ctrl_chk

bind ictc_ctrl ictc_ctrl_chk u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .iso_input_0, .iso_input_1, .iso_input_2, .iso_input_3, .iso_output_2, .iso_output_2_en,
  .iso_output_3, .iso_output_3_en, .first_counter_irq_flag, .second_counter_irq_flag);
`default_nettype wire

// [tb/ictc_field_model.sv]
// Field channel model: gate levels and clock pulse trains on the isolated inputs
`timescale 1ns/100ps
`default_nettype none
module ictc_field_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gate levels and pulse train requests, index 0 for counter 0
  input wire logic [1:0] gate,
  input wire logic [1:0] run,
  // Field inputs
  output logic iso_input_0,
  output logic iso_input_1,
  output logic iso_input_2,
  output logic iso_input_3
);
  logic [2:0] ph_q;
  always_ff @(posedge clk) begin
    ph_q <= rst ? 3'h0 : ph_q + 3'h1;
  end
  assign iso_input_0 = gate[0];
  assign iso_input_2 = gate[1];
  // rising edge every 8 cycles, idle low
  assign iso_input_1 = run[0] & ph_q[2];
  assign iso_input_3 = run[1] & ph_q[2];
endmodule // ictc_field_model
`default_nettype wire

// [tb/testbench.sv]
// Testbench: register traffic, field stimulus and a settings model for the control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ictc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] gate = 2'h0;
  logic [1:0] run = 2'h0;
  logic [7:0] rdata;
  logic iso_input_0, iso_input_1, iso_input_2, iso_input_3;
  logic iso_output_2, iso_output_2_en, iso_output_3, iso_output_3_en;
  logic first_counter_irq_flag, second_counter_irq_flag;
  int num_errors = 0;
  int compares = 0;
  int seed = 10292;
  int div[4] = '{4, 8, 12, 16};
  int m_set[2];
  int n, k;
  logic [7:0] d;
  always #12.5 clk = ~clk;
  ictc_ctrl #(.TB_DIV0(4), .TB_DIV1(8), .TB_DIV2(12), .TB_DIV3(16)) DUT (.clk, .rst, .addr,
    .wdata, .wr, .rd, .rdata, .iso_input_0, .iso_input_1, .iso_input_2, .iso_input_3,
    .iso_output_2, .iso_output_2_en, .iso_output_3, .iso_output_3_en,
    .first_counter_irq_flag, .second_counter_irq_flag);
  ictc_field_model u_field (.clk, .rst, .gate, .run, .iso_input_0, .iso_input_1,
    .iso_input_2, .iso_input_3);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let one edge pass so a following write never reassigns the strobe in this step
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 v = rdata;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask
  task automatic wait_flag(input int c);
    int w;
    w = 0;
    while ((c ? second_counter_irq_flag : first_counter_irq_flag) !== 1'b1 && w < 400) begin
      @(posedge clk);
      #1 w++;
    end
    chk({7'h0, w < 400}, 8'h01);
  endtask
  task automatic wait_fall(output int t);
    logic p;
    t = 0;
    do begin
      p = iso_output_2;
      @(posedge clk);
      #1 t++;
    end while (!(p === 1'b1 && iso_output_2 === 1'b0) && t < 2000);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(ICTC_OFF_IRQ_FLAGS, 8'h00);
    rd_chk(ICTC_OFF_GATE_OUT0, 8'h10);
    rd_chk(ICTC_OFF_GATE_OUT1, 8'h10);
    rd_chk(ICTC_OFF_SETTINGS1, 8'h00);
    rd_chk(10'h20a, 8'h00);
    wr_reg(ICTC_OFF_CORE_CTRL, 8'h36);
    rd_chk(ICTC_OFF_CORE_CTRL, 8'h36);
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 2; c++) begin
        m_set[c] = $random(seed) & (c ? 32'h7f : 32'h0f);
        wr_reg(10'(ICTC_OFF_SETTINGS0 + c), m_set[c][7:0]);
        rd_reg(10'(ICTC_OFF_SETTINGS0 + c), d);
        chk(d & (c ? 8'h7f : 8'h0f), m_set[c][7:0]);
        chk({7'h0, c ? iso_output_3_en : iso_output_2_en}, {7'h0, m_set[c][2]});
      end
    end
    wr_reg(ICTC_OFF_SETTINGS1, 8'h00);
    wr_reg(ICTC_OFF_CORE_DATA0, 8'h04);
    wr_reg(ICTC_OFF_CORE_DATA0, 8'h00);
    wr_reg(ICTC_OFF_GATE_OUT0, 8'h01);
    wr_reg(ICTC_OFF_SETTINGS0, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wr_reg(ICTC_OFF_SETTINGS1, 8'(s << 4));
      wait_fall(n);
      wait_fall(n);
      wait_fall(n);
      // Reload of 4 gives a terminal pulse every 3 time base ticks
      k = 3;
      chk(8'(n), 8'(k * div[s]));
    end
    rd_chk(ICTC_OFF_GATE_OUT0, 8'h01);
    repeat (20) @(posedge clk);
    rd_chk(ICTC_OFF_GATE_OUT0, 8'h11);
    wr_reg(ICTC_OFF_SETTINGS1, 8'h00);
    wr_reg(ICTC_OFF_IRQ_FLAGS, 8'h0c);
    wr_reg(ICTC_OFF_SETTINGS0, 8'h0c);
    wait_flag(0);
    rd_chk(ICTC_OFF_IRQ_FLAGS, 8'h04);
    wr_reg(ICTC_OFF_IRQ_FLAGS, 8'h00);
    #1 chk({7'h0, first_counter_irq_flag}, 8'h01);
    wr_reg(ICTC_OFF_SETTINGS0, 8'h04);
    wr_reg(ICTC_OFF_IRQ_FLAGS, 8'h04);
    repeat (200) @(posedge clk);
    rd_chk(ICTC_OFF_IRQ_FLAGS, 8'h00);
    for (int c = 0; c < 2; c++) begin
      wr_reg(10'(ICTC_OFF_CORE_DATA0 + c), 8'h03);
      wr_reg(10'(ICTC_OFF_CORE_DATA0 + c), 8'h00);
      wr_reg(10'(ICTC_OFF_SETTINGS0 + c), 8'h0f);
      wr_reg(ICTC_OFF_IRQ_FLAGS, 8'h0c);
      run[c] <= 1'b1;
      repeat (300) @(posedge clk);
      #1 chk({6'h0, second_counter_irq_flag, first_counter_irq_flag}, 8'h00);
      gate[c] <= 1'b1;
      wait_flag(c);
      run[c] <= 1'b0;
      repeat (10) @(posedge clk);
      wr_reg(ICTC_OFF_IRQ_FLAGS, 8'h0c);
      repeat (300) @(posedge clk);
      #1 chk({6'h0, second_counter_irq_flag, first_counter_irq_flag}, 8'h00);
      gate[c] <= 1'b0;
      wr_reg(10'(ICTC_OFF_SETTINGS0 + c), 8'h00);
    end
    wr_reg(ICTC_OFF_GATE_OUT1, 8'h01);
    wr_reg(ICTC_OFF_SETTINGS1, 8'h49);
    wait_flag(1);
    wr_reg(ICTC_OFF_SETTINGS1, 8'h09);
    repeat (10) @(posedge clk);
    wr_reg(ICTC_OFF_IRQ_FLAGS, 8'h08);
    repeat (300) @(posedge clk);
    #1 chk({7'h0, second_counter_irq_flag}, 8'h00);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
